// ---- logic/lpc_calib.sv ----
// Purpose: low power oscillator calibration counters, trim and APB registers
// Assumes: oscillator inputs are synchronous to core_clk and far slower than it
// Notes: one level interrupt for calibration done and abort events
// Functional notes
// - 9-bit reference counter counts precision oscillator or crystal edges.
// - 10-bit counter counts low power oscillator, direct or divided by four.
// - 4-bit trim in low bits; larger value slows the oscillator.
// - both counters stop when the reference counter reaches 0x1ff.
// - a run lasts about 4 ms precision-referenced, 16 ms crystal-referenced.
// - control bit 4 selects crystal (1) or precision oscillator (0).
// - control bit 3 resets both counters and disables calibration.
// - control bit 2 clears low power counter, bit 1 clears reference counter.
// - control bit 0 starts calibration; clearing it aborts a run.
// - status bit 1 set on completion, cleared by reading low power count.
// - status bit 0 reads one while calibration is running.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module lpc_calib
  import lpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic precOscClk,
  input wire logic xtalClk,
  input wire logic lpOscClk,
  output logic [TRIM_W-1:0] lpOscTrim,
  output logic calibIrq
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic known(input logic [ADDR_W-1:0] a);
    known = hit(a, OFF_LP_OSC_TRIM) | hit(a, OFF_CALIB_CONTROL) | hit(a, OFF_CALIB_STATUS) |
            hit(a, OFF_REFERENCE_COUNT) | hit(a, OFF_LP_OSC_COUNT) | hit(a, OFF_IRQ_STATUS) |
            hit(a, OFF_IRQ_MASK);
  endfunction

  lpc_state_t state_r;
  logic [TRIM_W-1:0] trim_r;
  logic ctrlEnable_r;
  logic ctrlReset_r;
  logic ctrlSrc_r;
  logic done_r;
  logic [REF_W-1:0] refCount_r;
  logic [LP_W-1:0] lpCount_r;
  logic [IRQ_W-1:0] irqStatus_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic [DATA_W-1:0] prdata_r;

  logic setupPhase;
  logic accessDone;
  logic wrEn;
  logic rdEn;
  logic ctrlWr;
  logic start;
  logic refTick;
  logic lpTick;
  logic refSrcClk;
  logic finish;
  logic abort;
  logic clrRef;
  logic clrLp;

  // APB: read data captured in setup, so the access phase never waits
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable;
  assign pready = 1'b1;
  assign pslverr = accessDone & ~known(paddr);
  assign prdata = prdata_r;
  assign wrEn = accessDone & pwrite & known(paddr);
  assign rdEn = accessDone & ~pwrite & known(paddr);
  assign ctrlWr = wrEn & hit(paddr, OFF_CALIB_CONTROL);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= 32'h0;
    end else if (setupPhase & ~pwrite) begin
      prdata_r <= 32'h0;
      if (hit(paddr, OFF_LP_OSC_TRIM)) begin
        prdata_r[TRIM_W-1:0] <= trim_r;
      end
      if (hit(paddr, OFF_CALIB_CONTROL)) begin
        prdata_r[CTRL_ENABLE_BIT] <= ctrlEnable_r;
        prdata_r[CTRL_RESET_BIT] <= ctrlReset_r;
        prdata_r[CTRL_SRC_BIT] <= ctrlSrc_r;
      end
      if (hit(paddr, OFF_CALIB_STATUS)) begin
        prdata_r[STA_BUSY_BIT] <= (state_r == LPC_RUN);
        prdata_r[STA_DONE_BIT] <= done_r;
      end
      if (hit(paddr, OFF_REFERENCE_COUNT)) begin
        prdata_r[REF_W-1:0] <= refCount_r;
      end
      if (hit(paddr, OFF_LP_OSC_COUNT)) begin
        prdata_r[LP_W-1:0] <= lpCount_r;
      end
      if (hit(paddr, OFF_IRQ_STATUS)) begin
        prdata_r[IRQ_W-1:0] <= irqStatus_r;
      end
      if (hit(paddr, OFF_IRQ_MASK)) begin
        prdata_r[IRQ_W-1:0] <= irqMask_r;
      end
    end
  end

  // trim field, reserved upper bits not stored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trim_r <= TRIM_RESET;
    end else if (wrEn & hit(paddr, OFF_LP_OSC_TRIM)) begin
      trim_r <= pwdata[TRIM_W-1:0];
    end
  end
  assign lpOscTrim = trim_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlReset_r <= 1'b0;
      ctrlSrc_r <= 1'b0;
    end else if (ctrlWr) begin
      ctrlReset_r <= pwdata[CTRL_RESET_BIT];
      ctrlSrc_r <= pwdata[CTRL_SRC_BIT];
    end
  end

  // enable; a software write outranks the hardware clear on completion
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlEnable_r <= 1'b0;
    end else if (ctrlWr) begin
      ctrlEnable_r <= pwdata[CTRL_ENABLE_BIT];
    end else if (finish) begin
      ctrlEnable_r <= 1'b0;
    end
  end

  assign clrRef = ctrlWr & pwdata[CTRL_CLR_REF_BIT];
  assign clrLp = ctrlWr & pwdata[CTRL_CLR_LP_BIT];

  assign refSrcClk = ctrlSrc_r ? xtalClk : precOscClk;
  assign start = (state_r == LPC_IDLE) & ctrlEnable_r & ~ctrlReset_r;

  lpc_edge_div refEdge (
    .core_clk(core_clk),
    .resetn(resetn),
    .clkIn(refSrcClk),
    .divBy4(1'b0),
    .clr(start),
    .tick(refTick)
  );

  lpc_edge_div lpEdge (
    .core_clk(core_clk),
    .resetn(resetn),
    .clkIn(lpOscClk),
    .divBy4(ctrlSrc_r),
    .clr(start),
    .tick(lpTick)
  );

  // run length is 511 reference edges
  // terminal reference count ends the run
  assign finish = (state_r == LPC_RUN) & refTick & (refCount_r == REF_TERMINAL - 9'h1);
  // abort on enable cleared or reset set
  assign abort = (state_r == LPC_RUN) & (~ctrlEnable_r | ctrlReset_r);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= LPC_IDLE;
    end else begin
      case (state_r)
        LPC_IDLE: begin
          if (start) begin
            state_r <= LPC_RUN;
          end
        end
        LPC_RUN: begin
          if (finish | abort) begin
            state_r <= LPC_IDLE;
          end
        end
        default: begin
          state_r <= LPC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      refCount_r <= '0;
    end else if (ctrlReset_r | clrRef | start) begin
      refCount_r <= '0;
    end else if ((state_r == LPC_RUN) & ~abort & refTick) begin
      refCount_r <= refCount_r + 9'h1;
    end
  end

  // low power oscillator counter, held at its top to avoid wrap
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lpCount_r <= '0;
    end else if (ctrlReset_r | clrLp | start) begin
      lpCount_r <= '0;
    end else if ((state_r == LPC_RUN) & ~abort & lpTick & (lpCount_r != LP_MAX)) begin
      lpCount_r <= lpCount_r + 10'h1;
    end
  end

  // done flag; completion wins over the read that clears it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_r <= 1'b0;
    end else if (finish) begin
      done_r <= 1'b1;
    end else if (rdEn & hit(paddr, OFF_LP_OSC_COUNT)) begin
      done_r <= 1'b0;
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irqStatus_r <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_DONE_BIT && finish) || (i == IRQ_ABORT_BIT && abort)) begin
          irqStatus_r[i] <= 1'b1;
        end else if (wrEn & hit(paddr, OFF_IRQ_STATUS) & pwdata[i]) begin
          irqStatus_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irqMask_r <= '0;
    end else if (wrEn & hit(paddr, OFF_IRQ_MASK)) begin
      irqMask_r <= pwdata[IRQ_W-1:0];
    end
  end

  assign calibIrq = |(irqStatus_r & irqMask_r);

endmodule // lpc_calib

// ---- common/lpc_pkg.sv ----
// Purpose: shared constants and types for the low power oscillator calibration block
// Assumes: 32-bit APB, byte addresses as printed
// Notes: counters are sampled from the oscillator inputs on core_clk
package lpc_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [31:0] OFF_LP_OSC_TRIM = 32'hffff042c;
  localparam logic [31:0] OFF_CALIB_CONTROL = 32'hffff0440;
  localparam logic [31:0] OFF_CALIB_STATUS = 32'hffff0444;
  localparam logic [31:0] OFF_REFERENCE_COUNT = 32'hffff0448;
  localparam logic [31:0] OFF_LP_OSC_COUNT = 32'hffff044c;
  localparam logic [31:0] OFF_IRQ_STATUS = 32'hffff0450;
  localparam logic [31:0] OFF_IRQ_MASK = 32'hffff0454;

  // calib_control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLR_REF_BIT = 1;
  localparam int CTRL_CLR_LP_BIT = 2;
  localparam int CTRL_RESET_BIT = 3;
  localparam int CTRL_SRC_BIT = 4;

  // calib_status fields
  localparam int STA_BUSY_BIT = 0;
  localparam int STA_DONE_BIT = 1;

  // interrupt status / mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;

  localparam int TRIM_W = 4;
  localparam int REF_W = 9;
  localparam int LP_W = 10;

  localparam logic [TRIM_W-1:0] TRIM_RESET = 4'h8;
  localparam logic [REF_W-1:0] REF_TERMINAL = 9'h1ff;
  localparam logic [LP_W-1:0] LP_MAX = 10'h3ff;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  typedef enum logic {
    LPC_IDLE,
    LPC_RUN
  } lpc_state_t;

endpackage

// ---- logic/lpc_edge_div.sv ----
// Purpose: rising edge detector with optional divide-by-four on a slow oscillator input
// Assumes: clkIn is much slower than core_clk and synchronous to it
// Notes: tick is a one-cycle pulse per counted edge
`timescale 1ns/1ps
module lpc_edge_div
  import lpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkIn,
  input wire logic divBy4,
  input wire logic clr,
  output logic tick
);

  logic prev_r;
  logic [1:0] divCnt_r;
  logic rise;

  assign rise = clkIn & ~prev_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= clkIn;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 2'h0;
    end else if (clr) begin
      divCnt_r <= 2'h0;
    end else if (rise) begin
      divCnt_r <= divCnt_r + 2'h1;
    end
  end

  assign tick = rise & (~divBy4 | (divCnt_r == DIV4_LAST));

endmodule // lpc_edge_div

// ---- sim/lpc_calib_props.sv ----
// Purpose: port checks for lpc_calib
// Assumes: one core_clk domain, zero wait APB
// Notes: register contents seen via prdata, and trim also via the lpOscTrim port
`timescale 1ns/1ps
module lpc_calib_props
  import lpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic precOscClk,
  input wire logic xtalClk,
  input wire logic lpOscClk,
  input wire logic [TRIM_W-1:0] lpOscTrim,
  input wire logic calibIrq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic mapped;
  assign mapped = paddr inside {OFF_LP_OSC_TRIM, OFF_CALIB_CONTROL, OFF_CALIB_STATUS,
    OFF_REFERENCE_COUNT, OFF_LP_OSC_COUNT, OFF_IRQ_STATUS, OFF_IRQ_MASK};
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rd(a);
    s_acc ##0 !pwrite && paddr == a;
  endsequence
  sequence s_trim_wr;
    s_acc ##0 pwrite && paddr == OFF_LP_OSC_TRIM;
  endsequence
  a_unmapped_err: assert property (s_acc ##0 !mapped && !pwrite |-> pslverr && prdata == 0)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (s_acc ##0 mapped |-> !pslverr)
    else $error("mapped access refused");
  a_trim_load: assert property (s_trim_wr |=> lpOscTrim == $past(pwdata[3:0]))
    else $error("trim not loaded");
  a_trim_hold: assert property (!(psel && penable && pwrite && paddr == OFF_LP_OSC_TRIM)
    |=> $stable(lpOscTrim)) else $error("trim changed without write");
  a_trim_read: assert property (s_rd(OFF_LP_OSC_TRIM) |-> prdata == {28'h0, lpOscTrim})
    else $error("trim readback wrong");
  a_ref_width: assert property (s_rd(OFF_REFERENCE_COUNT) |-> prdata[31:9] == 0)
    else $error("reference count too wide");
  a_lp_width: assert property (s_rd(OFF_LP_OSC_COUNT) |-> prdata[31:10] == 0)
    else $error("lp count too wide");
  a_status_rsvd: assert property (s_rd(OFF_CALIB_STATUS) |-> prdata[31:2] == 0)
    else $error("status reserved bits set");
  a_ctl_oneshot: assert property (s_rd(OFF_CALIB_CONTROL) |-> prdata[31:5] == 0 && prdata[2:1] == 0)
    else $error("control one-shot bits read back");
endmodule // lpc_calib_props

bind lpc_calib lpc_calib_props chk_u (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .precOscClk, .xtalClk, .lpOscClk, .lpOscTrim, .calibIrq);

// ---- sim/lpc_calib_tb.sv ----
// Purpose: self-checking bench for lpc_calib
// Assumes: oscillators run free at 8 and 32 core cycles
// Notes: fast reference keeps a run near 4k cycles
`timescale 1ns/1ps
module lpc_calib_tb
  import lpc_pkg::*;
;
  typedef struct {bit w; logic [31:0] a, d, e;} lpc_row_t;
  logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic pready, pslverr, calibIrq, err;
  logic precOscClk = 0, xtalClk = 0, lpOscClk = 0;
  logic [3:0] lpOscTrim;
  logic [7:0] cyc = 0;
  int nFail = 0, cmpCount = 0, n;
  lpc_row_t rows[10] = '{'{0, OFF_LP_OSC_TRIM, 0, 8}, '{0, OFF_CALIB_CONTROL, 0, 0},
    '{0, OFF_CALIB_STATUS, 0, 0}, '{0, OFF_REFERENCE_COUNT, 0, 0}, '{0, OFF_LP_OSC_COUNT, 0, 0},
    '{0, OFF_IRQ_STATUS, 0, 0}, '{0, OFF_IRQ_MASK, 0, 0}, '{1, OFF_LP_OSC_TRIM, 'h0f, 'hf},
    '{1, OFF_CALIB_CONTROL, 'h16, 'h10}, '{1, OFF_IRQ_MASK, 3, 3}};

  lpc_calib dut_u (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .precOscClk, .xtalClk, .lpOscClk, .lpOscTrim, .calibIrq);

  initial forever #12.5 core_clk = ~core_clk;
  // reference sources run from reset, before any start
  // same nominal rate: lp/4 matches crystal
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    precOscClk <= cyc[2];
    lpOscClk <= cyc[2];
    xtalClk <= cyc[4];
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    cmpCount++;
    if (s !== e) begin
      nFail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input bit w, input logic [31:0] a, d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [31:0] a, e);
    apb(0, a, 0);
    chk(r, e);
  endtask
  task automatic irqIs(input logic e);
    @(negedge core_clk);
    chk(calibIrq, e);
  endtask
  // bounded wait, watchdog is the backstop
  task automatic waitIrq();
    for (n = 0; n < 20000 && calibIrq !== 1; n++) @(posedge core_clk);
  endtask
  task automatic startWait(input logic [31:0] c, int k);
    apb(1, OFF_CALIB_CONTROL, c);
    repeat (k) @(posedge core_clk);
  endtask

  initial begin
    #1000000;
    nFail++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    chk(lpOscTrim, 8);
    resetn <= 1;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    startWait(1, 0);
    waitIrq();
    chk(n inside {[4076:4100]}, 1);
    rd(OFF_CALIB_STATUS, 2);
    rd(OFF_REFERENCE_COUNT, 'h1ff);
    apb(0, OFF_LP_OSC_COUNT, 0);
    chk(r inside {[509:513]}, 1);
    if (r < 'h1ff) apb(1, OFF_LP_OSC_TRIM, 'he);
    else if (r > 'h1ff) apb(1, OFF_LP_OSC_TRIM, 'hf);
    rd(OFF_CALIB_STATUS, 0);
    rd(OFF_CALIB_CONTROL, 0);
    apb(1, OFF_IRQ_STATUS, 1);
    irqIs(0);
    startWait('h11, 0);
    rd(OFF_CALIB_STATUS, 1);
    waitIrq();
    chk(n inside {[16300:16360]}, 1);
    apb(0, OFF_LP_OSC_COUNT, 0);
    chk(r inside {[509:513]}, 1);
    rd(OFF_CALIB_CONTROL, 'h10);
    apb(1, OFF_CALIB_CONTROL, 4);
    rd(OFF_LP_OSC_COUNT, 0);
    rd(OFF_REFERENCE_COUNT, 'h1ff);
    apb(1, OFF_CALIB_CONTROL, 2);
    rd(OFF_REFERENCE_COUNT, 0);
    apb(1, OFF_IRQ_STATUS, 3);
    startWait(1, 60);
    apb(1, OFF_CALIB_CONTROL, 0);
    rd(OFF_CALIB_STATUS, 0);
    rd(OFF_IRQ_STATUS, 2);
    apb(0, OFF_REFERENCE_COUNT, 0);
    chk(r inside {[5:9]}, 1);
    apb(1, OFF_IRQ_MASK, 1);
    irqIs(0);
    apb(1, OFF_IRQ_MASK, 3);
    irqIs(1);
    apb(1, OFF_IRQ_STATUS, 2);
    irqIs(0);
    startWait(1, 60);
    startWait(8, 0);
    rd(OFF_CALIB_STATUS, 0);
    rd(OFF_REFERENCE_COUNT, 0);
    rd(OFF_LP_OSC_COUNT, 0);
    startWait(9, 40);
    rd(OFF_REFERENCE_COUNT, 0);
    apb(0, 'hffff0458, 0);
    chk(err, 1);
    chk(r, 0);
    startWait(1, 20);
    resetn <= 0;
    @(posedge core_clk);
    resetn <= 1;
    rd(OFF_CALIB_STATUS, 0);
    rd(OFF_LP_OSC_TRIM, 8);
    rd(OFF_REFERENCE_COUNT, 0);
    final_report();
  end
endmodule // lpc_calib_tb
